// *** rtl/kbil_consts.svh ***
// Offsets, field positions and reset values of the keypad interrupt latch
`ifndef KBIL_CONSTS_SVH
`define KBIL_CONSTS_SVH
`define KBIL_ADDR_W 8
`define KBIL_OFF_PIN_ENABLE 8'h1B
`define KBIL_OFF_STATUS_CONTROL 8'h1A
`define KBIL_OFF_PORT_DIR 8'h1C
`define KBIL_OFF_PORT_READ 8'h1D
`define KBIL_OFF_BREAK_CTRL 8'h1E
`define KBIL_BIT_PENDING 3
`define KBIL_BIT_ACK 2
`define KBIL_BIT_MASK 1
`define KBIL_BIT_LEVEL 0
`define KBIL_BIT_BREAK_CLEAR_ENABLE 0
`define KBIL_RST_BYTE 8'h00
`define KBIL_ZERO_WORD 32'h0000_0000
`define KBIL_ALL_ONES_BYTE 8'hFF
`define KBIL_VECTOR_HI 16'hFFE0
`define KBIL_VECTOR_LO 16'hFFE1
`endif

// *** rtl/kbil_pkg.sv ***
// Types shared by the keypad interrupt latch
package kbil_pkg;
    typedef struct packed {
        logic level_mode_select;
        logic request_mask;
    } kbil_ctrl_s;
    typedef enum logic [1:0] {
        KBIL_IDLE = 2'b00,
        KBIL_DATA = 2'b01
    } kbil_bus_e;
endpackage

// *** rtl/kbil_latch.sv ***
// Keypad interrupt latch with Avalon-MM register slave
// Summary of operation
// - Latch request when an enabled pin falls while all enabled pins were high
// - Eight individually enabled keypad inputs share one latch and one mask
// - Level mode: falling edges and lows; clear needs ack plus all pins high
// - Keypad vector fetch acts as acknowledge clearing the request
// - Writing 1 to the acknowledge bit gives the same acknowledge
// - Falling edges after a software acknowledge latch a new request
// - Unmasked latched request makes the CPU take vector at FFE0/FFE1
// - Level mode holds the request while any enabled pin is low
// - Level mode accepts acknowledge and pin release in either order
// - Edge mode: acknowledge clears the request at once
// - Reset clears request and level mode even with a pin held low
// - Pending flag shows the request whatever the mask
// - Enable forces pin to input; pin read only with direction bit 0
// - Break clear-enable 1 lets ack clear latch in break; stays cleared
// - Break clear-enable 0 makes software acks in break do nothing; vector fetch still clears
// - Status bits 7 to 4 read zero and ignore writes
// - Pending flag is read only, set while pending, cleared by reset
// - Acknowledge bit is write only, reads zero, reset clears it
// - Mask bit read/write; 1 blocks CPU request; reset clears it
// - Level mode bit read/write; 1 adds low levels; reset clears it
// - Enable register at 001B, bit n enables pin n, resets to zero
// - Keypad logic runs in wait and stop to wake the processor
`timescale 1ns/100ps
`include "kbil_consts.svh"
`default_nettype none
module kbil_latch (
    input wire logic clk_in, // Bus clock, 250 MHz
    input wire logic rstn_in, // Synchronous reset, active low
    input wire logic ce_in, // Clock enable, freezes state when low
    input wire logic [7:0] port_a_pin_in, // Asynchronous keypad pins
    input wire logic vector_fetch_in, // CPU fetching the keypad vector
    input wire logic break_state_in, // Debug break state active
    input wire logic [7:0] avs_address_in, // Byte address
    input wire logic avs_read_in, // Read request
    input wire logic avs_write_in, // Write request
    input wire logic [31:0] avs_writedata_in, // Write data
    input wire logic [3:0] avs_byteenable_in, // Byte enables
    output logic [31:0] avs_readdata_out, // Read data
    output logic avs_waitrequest_out, // Stall until answer ready
    output logic avs_response_out, // Low: okay, high: unmapped
    output logic irq_out, // CPU keypad interrupt request
    output logic [7:0] pin_input_force_out // Pins forced to input
);
    logic [7:0] sync1_r, sync2_r, sync3_r;
    logic [7:0] sync1_nxt, sync2_nxt, sync3_nxt;
    logic [7:0] pin_en_r, pin_en_nxt, dir_r, dir_nxt;
    kbil_pkg::kbil_ctrl_s ctrl_r, ctrl_nxt;
    logic break_clear_enable_r, break_clear_enable_nxt;
    logic req_r, req_nxt;
    logic ack_pend_r, ack_pend_nxt;
    logic irq_r, irq_nxt;
    logic [7:0] force_r, force_nxt;
    kbil_pkg::kbil_bus_e bus_r, bus_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wait_r, wait_nxt;
    logic resp_r, resp_nxt;
    logic any_low_now, any_low_prev, fall, ack, wr_go, lane0, mapped;
    logic [7:0] wbyte, rbyte;

    // Pin synchroniser; only sync2 onward feeds detection
    always_comb begin
        sync1_nxt = port_a_pin_in;
        sync2_nxt = sync1_r;
        sync3_nxt = sync2_r;
    end
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            sync1_r <= `KBIL_ALL_ONES_BYTE;
            sync2_r <= `KBIL_ALL_ONES_BYTE;
            sync3_r <= `KBIL_ALL_ONES_BYTE;
        end else if (ce_in) begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            sync3_r <= sync3_nxt;
        end
    end

    // Bus decode
    always_comb begin
        wbyte = avs_writedata_in[7:0];
        lane0 = avs_byteenable_in[0];
        wr_go = (bus_r == kbil_pkg::KBIL_IDLE) && avs_write_in && lane0;
        mapped = (avs_address_in == `KBIL_OFF_PIN_ENABLE) ||
                 (avs_address_in == `KBIL_OFF_STATUS_CONTROL) ||
                 (avs_address_in == `KBIL_OFF_PORT_DIR) ||
                 (avs_address_in == `KBIL_OFF_PORT_READ) ||
                 (avs_address_in == `KBIL_OFF_BREAK_CTRL);
    end

    // Detection and latch
    always_comb begin
        any_low_now = |(~sync2_r & pin_en_r);
        // Previous sample under today's enables, so a newly enabled low pin does not count as a fall
        any_low_prev = |(~sync3_r & pin_en_r);
        fall = any_low_now && !any_low_prev;
        // Acknowledge from software write, or from vector fetch
        ack = (wr_go && avs_address_in == `KBIL_OFF_STATUS_CONTROL &&
               wbyte[`KBIL_BIT_ACK]) || vector_fetch_in;
        if (break_state_in && !break_clear_enable_r) begin
            ack = vector_fetch_in;
        end
        // Cleared in break stays cleared: nothing restores it
        ack_pend_nxt = ack_pend_r;
        req_nxt = req_r;
        if (ctrl_r.level_mode_select) begin
            // Held ack waits for release of all pins, either order
            if (ack || ack_pend_r) begin
                if (!any_low_now) begin
                    req_nxt = 1'b0;
                    ack_pend_nxt = 1'b0;
                end else begin
                    ack_pend_nxt = req_r || fall;
                end
            end
            if (any_low_now && (fall || req_r && !(ack || ack_pend_r))) begin
                req_nxt = 1'b1;
            end
            if (any_low_now && !req_r) begin
                req_nxt = 1'b1;
            end
        end else begin
            ack_pend_nxt = 1'b0;
            if (ack) begin
                req_nxt = 1'b0;
            end
            // New edge beats a simultaneous acknowledge
            if (fall) begin
                req_nxt = 1'b1;
            end
        end
        // Logic runs from the bus clock while ce_in is high; no wait or stop input gates it
        irq_nxt = req_nxt && !ctrl_r.request_mask;
        force_nxt = pin_en_r;
    end
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            req_r <= 1'b0;
            ack_pend_r <= 1'b0;
            irq_r <= 1'b0;
            force_r <= `KBIL_RST_BYTE;
        end else if (ce_in) begin
            req_r <= req_nxt;
            ack_pend_r <= ack_pend_nxt;
            irq_r <= irq_nxt;
            force_r <= force_nxt;
        end
    end

    // Register file
    always_comb begin
        pin_en_nxt = pin_en_r;
        dir_nxt = dir_r;
        ctrl_nxt = ctrl_r;
        break_clear_enable_nxt = break_clear_enable_r;
        if (wr_go) begin
            case (avs_address_in)
                `KBIL_OFF_PIN_ENABLE: begin
                    pin_en_nxt = wbyte;
                end
                `KBIL_OFF_STATUS_CONTROL: begin
                    // Upper bits and pending flag ignore writes
                    ctrl_nxt.request_mask = wbyte[`KBIL_BIT_MASK];
                    ctrl_nxt.level_mode_select = wbyte[`KBIL_BIT_LEVEL];
                end
                `KBIL_OFF_PORT_DIR: begin
                    dir_nxt = wbyte;
                end
                `KBIL_OFF_BREAK_CTRL: begin
                    break_clear_enable_nxt = wbyte[`KBIL_BIT_BREAK_CLEAR_ENABLE];
                end
                default: begin
                    break_clear_enable_nxt = break_clear_enable_r;
                end
            endcase
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pin_en_r <= `KBIL_RST_BYTE;
            dir_r <= `KBIL_RST_BYTE;
            ctrl_r <= '0;
            break_clear_enable_r <= 1'b0;
        end else if (ce_in) begin
            pin_en_r <= pin_en_nxt;
            dir_r <= dir_nxt;
            ctrl_r <= ctrl_nxt;
            break_clear_enable_r <= break_clear_enable_nxt;
        end
    end

    // Avalon slave: one wait cycle, answer on the second edge
    always_comb begin
        rbyte = `KBIL_RST_BYTE;
        case (avs_address_in)
            `KBIL_OFF_PIN_ENABLE: begin
                rbyte = pin_en_r;
            end
            `KBIL_OFF_STATUS_CONTROL: begin
                rbyte[`KBIL_BIT_PENDING] = req_r;
                rbyte[`KBIL_BIT_ACK] = 1'b0;
                rbyte[`KBIL_BIT_MASK] = ctrl_r.request_mask;
                rbyte[`KBIL_BIT_LEVEL] = ctrl_r.level_mode_select;
            end
            `KBIL_OFF_PORT_DIR: begin
                rbyte = dir_r;
            end
            `KBIL_OFF_PORT_READ: begin
                rbyte = sync2_r & ~dir_r;
            end
            `KBIL_OFF_BREAK_CTRL: begin
                rbyte[`KBIL_BIT_BREAK_CLEAR_ENABLE] = break_clear_enable_r;
            end
            default: begin
                rbyte = `KBIL_RST_BYTE;
            end
        endcase
        bus_nxt = bus_r;
        rdata_nxt = rdata_r;
        wait_nxt = 1'b1;
        resp_nxt = resp_r;
        case (bus_r)
            kbil_pkg::KBIL_IDLE: begin
                if (avs_read_in || avs_write_in) begin
                    bus_nxt = kbil_pkg::KBIL_DATA;
                    wait_nxt = 1'b0;
                    resp_nxt = !mapped;
                    rdata_nxt = `KBIL_ZERO_WORD;
                    if (avs_read_in && mapped) begin
                        rdata_nxt[7:0] = rbyte;
                    end
                end
            end
            kbil_pkg::KBIL_DATA: begin
                bus_nxt = kbil_pkg::KBIL_IDLE;
            end
            default: begin
                bus_nxt = kbil_pkg::KBIL_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            bus_r <= kbil_pkg::KBIL_IDLE;
            rdata_r <= `KBIL_ZERO_WORD;
            wait_r <= 1'b1;
            resp_r <= 1'b0;
        end else if (ce_in) begin
            bus_r <= bus_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
            resp_r <= resp_nxt;
        end
    end

    always_comb begin
        avs_readdata_out = rdata_r;
        avs_waitrequest_out = wait_r;
        avs_response_out = resp_r;
        irq_out = irq_r;
        pin_input_force_out = force_r;
    end
endmodule // kbil_latch
`default_nettype wire

// *** tb/kbil_checker.sv ***
// Port-level assertions for the keypad interrupt latch
`timescale 1ns/100ps
`include "kbil_consts.svh"
`default_nettype none
module kbil_checker (
    input wire logic clk_in, // Bus clock
    input wire logic rstn_in, // Sync reset, active low
    input wire logic [7:0] port_a_pin_in, // Keypad pins
    input wire logic vector_fetch_in, // Vector fetch
    input wire logic [7:0] avs_address_in, // Address
    input wire logic avs_read_in, // Read
    input wire logic avs_write_in, // Write
    input wire logic [31:0] avs_writedata_in, // Write data
    input wire logic [3:0] avs_byteenable_in, // Lanes
    input wire logic [31:0] avs_readdata_out, // Read data
    input wire logic avs_waitrequest_out, // Stall
    input wire logic irq_out // CPU request
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    logic [1:0] ctl_r;
    logic [7:0] en_r;
    logic wr_st;
    logic st_rd;
    logic quiet;
    logic low_en;
    // Shadow of mask, mode and enables, taken at the write's taking edge
    assign wr_st = avs_write_in && avs_waitrequest_out && avs_byteenable_in[0];
    assign st_rd = avs_read_in && !avs_waitrequest_out
        && avs_address_in == `KBIL_OFF_STATUS_CONTROL;
    assign quiet = !avs_write_in && !vector_fetch_in && !ctl_r[1];
    assign low_en = |(~port_a_pin_in & en_r);
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            ctl_r <= 2'b00;
            en_r <= 8'h00;
        end else if (wr_st && avs_address_in == `KBIL_OFF_STATUS_CONTROL) begin
            ctl_r <= avs_writedata_in[1:0];
        end else if (wr_st && avs_address_in == `KBIL_OFF_PIN_ENABLE) begin
            en_r <= avs_writedata_in[7:0];
        end
    end
    sequence s_fall;
        (!low_en && quiet) ##1 (low_en && quiet)[*4];
    endsequence
    a_one_wait: assert property (
        (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("Bus answer late");
    a_status_zero: assert property (st_rd |-> avs_readdata_out[7:4] == 4'h0)
        else $error("Status upper bits set");
    a_ack_zero: assert property (st_rd |-> !avs_readdata_out[2])
        else $error("Ack bit reads one");
    a_mask_blocks: assert property (ctl_r[1] && $past(ctl_r[1]) |-> !irq_out)
        else $error("Masked request reached CPU");
    a_fall_raises: assert property (s_fall |=> irq_out)
        else $error("Fall did not raise request");
    a_edge_ack: assert property (
        (!ctl_r[0] && !avs_write_in && $stable(port_a_pin_in))[*4] ##0 vector_fetch_in
        |-> ##2 !irq_out) else $error("Fetch did not clear");
    a_level_hold: assert property (
        (ctl_r[0] && !ctl_r[1] && low_en && !avs_write_in)[*5] |-> irq_out)
        else $error("Level request dropped");
    a_reset_quiet: assert property ($rose(rstn_in) |-> !irq_out && avs_waitrequest_out)
        else $error("Request alive after reset");
endmodule // kbil_checker
bind kbil_latch kbil_checker kbil_checker_i (.clk_in(clk_in), .rstn_in(rstn_in),
    .port_a_pin_in(port_a_pin_in), .vector_fetch_in(vector_fetch_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out));
`default_nettype wire

// *** tb/kbil_keys.sv ***
// Keypad switch model on the port pins
`timescale 1ns/100ps
`default_nettype none
module kbil_keys (
    input wire logic [7:0] press_in, // Keys held down
    output logic [7:0] pin_out // Pin levels
);
    // Pull-ups take released pins high
    assign pin_out = ~press_in;
endmodule // kbil_keys
`default_nettype wire

// *** tb/kbil_latch_tb.sv ***
// Register-level bench for the keypad interrupt latch
`timescale 1ns/100ps
`default_nettype none
module kbil_latch_tb;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic vf = 1'b0;
    logic brk = 1'b0;
    logic wen = 1'b0;
    logic ren = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [7:0] press = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] q;
    logic [7:0] pins;
    logic [7:0] frc;
    logic wreq;
    logic resp;
    logic irq;
    int n_fail = 0;
    int num_checks = 0;
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    kbil_keys kbil_keys_i (.press_in(press), .pin_out(pins));
    kbil_latch kbil_latch_i (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(1'b1),
        .port_a_pin_in(pins), .vector_fetch_in(vf), .break_state_in(brk),
        .avs_address_in(adr), .avs_read_in(ren), .avs_write_in(wen),
        .avs_writedata_in(wdat), .avs_byteenable_in(4'hF), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wreq), .avs_response_out(resp), .irq_out(irq),
        .pin_input_force_out(frc));
    task automatic tick(input int c);
        repeat (c) @(posedge clk_in);
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Holds the request until waitrequest is seen low, then one idle edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        adr <= a;
        wdat <= {24'h00_0000, d};
        wen <= w;
        ren <= ~w;
        @(posedge clk_in);
        while (wreq !== 1'b0 && n < 20) begin
            @(posedge clk_in);
            n++;
        end
        q = rdat;
        wen <= 1'b0;
        ren <= 1'b0;
        @(posedge clk_in);
        if (n >= 20) begin
            n_fail++;
            stop_test();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q[7:0], e);
    endtask
    initial begin
        tick(20);
        rstn_in <= 1'b1;
        tick(1);
        rd(8'h1A, 8'h00);
        rd(8'h1B, 8'h00);
        rd(8'h40, 8'h00);
        chk({7'h00, resp}, 8'h01);
        bus(1'b1, 8'h1A, 8'h02);
        bus(1'b1, 8'h1C, 8'h0F);
        rd(8'h1D, 8'hF0);
        bus(1'b1, 8'h1C, 8'h00);
        bus(1'b1, 8'h1B, 8'hFF);
        bus(1'b1, 8'h1A, 8'hF6);
        rd(8'h1A, 8'h02);
        bus(1'b1, 8'h1A, 8'h00);
        chk(frc, 8'hFF);
        $display("test setup done");
        press <= 8'h01;
        tick(6);
        chk({7'h00, irq}, 8'h01);
        rd(8'h1A, 8'h08);
        bus(1'b1, 8'h1A, 8'h04);
        rd(8'h1A, 8'h00);
        press <= 8'h03;
        tick(6);
        rd(8'h1A, 8'h00);
        press <= 8'h00;
        tick(4);
        press <= 8'h80;
        tick(6);
        rd(8'h1A, 8'h08);
        vf <= 1'b1;
        tick(1);
        vf <= 1'b0;
        tick(2);
        chk({7'h00, irq}, 8'h00);
        $display("test edge done");
        press <= 8'h00;
        bus(1'b1, 8'h1A, 8'h02);
        press <= 8'h10;
        tick(6);
        chk({7'h00, irq}, 8'h00);
        rd(8'h1A, 8'h0A);
        bus(1'b1, 8'h1A, 8'h00);
        brk <= 1'b1;
        bus(1'b1, 8'h1A, 8'h04);
        rd(8'h1A, 8'h08);
        bus(1'b1, 8'h1E, 8'h01);
        bus(1'b1, 8'h1A, 8'h04);
        brk <= 1'b0;
        rd(8'h1A, 8'h00);
        $display("test mask and break done");
        press <= 8'h00;
        bus(1'b1, 8'h1A, 8'h01);
        press <= 8'h08;
        tick(6);
        bus(1'b1, 8'h1A, 8'h05);
        rd(8'h1A, 8'h09);
        press <= 8'h00;
        tick(5);
        rd(8'h1A, 8'h01);
        press <= 8'h08;
        tick(6);
        press <= 8'h00;
        tick(5);
        rd(8'h1A, 8'h09);
        bus(1'b1, 8'h1A, 8'h05);
        rd(8'h1A, 8'h01);
        press <= 8'h08;
        rstn_in <= 1'b0;
        tick(20);
        rstn_in <= 1'b1;
        tick(1);
        rd(8'h1A, 8'h00);
        $display("test level done");
        stop_test();
    end
endmodule // kbil_latch_tb
`default_nettype wire
